// ### hdl/ccp_pkg.sv
package ccp_pkg;

   // ************************************************************
   // timing
   // ************************************************************
   localparam int CLK_MHZ       = 250;
   localparam int POR_SHORT_US  = 2000;
   localparam int POR_LONG_US   = 100000;
   localparam int RESTART_US    = 2;
   localparam int DONE_WAIT_US  = 4;
   localparam int CNT_W         = 25;

   localparam logic [CNT_W-1:0] RESTART_CNT   = CNT_W'(RESTART_US * CLK_MHZ);
   localparam logic [CNT_W-1:0] DONE_WAIT_CNT = CNT_W'(DONE_WAIT_US * CLK_MHZ);

   // ************************************************************
   // register map and fields
   // ************************************************************
   localparam logic [7:0]  ADDR_CTRL    = 8'h00;
   localparam logic [7:0]  ADDR_LEN     = 8'h04;
   localparam logic [7:0]  ADDR_STATUS  = 8'h08;

   localparam int          CTRL_EXT_BIT = 0;
   localparam int          CTRL_DIV_LSB = 8;
   localparam int          DIV_W        = 8;
   localparam logic [7:0]  DIV_RESET    = 8'h04;
   localparam logic [7:0]  DIV_MIN      = 8'h04;
   localparam int          LEN_W        = 16;
   localparam logic [15:0] LEN_RESET    = 16'h0100;
   localparam int          STAT_CS_BIT  = 8;
   localparam int          STAT_ERR_BIT = 24;
   localparam int          PAGE_W       = 3;
   localparam int          DATA_W       = 8;
   localparam int          ADDR_W       = PAGE_W + LEN_W;

   // ************************************************************
   // sequencer states
   // ************************************************************
   typedef enum logic [5:0] {
      ST_RESET     = 6'b000001,
      ST_WAIT_RISE = 6'b000010,
      ST_CONFIG    = 6'b000100,
      ST_CHECK     = 6'b001000,
      ST_USER      = 6'b010000,
      ST_IDLE      = 6'b100000
   } ccp_state_t;

endpackage : ccp_pkg

// ### hdl/ccp_sync.sv
`timescale 1ns/1ps
module ccp_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             nrst,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   // first stage is read only by the second stage
   logic [WIDTH-1:0] meta;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         meta <= '0;
         q    <= '0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end

endmodule : ccp_sync

// ### hdl/ccp_por_seq.sv
// Decided for this implementation: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
module ccp_por_seq
   import ccp_pkg::*;
#(
   parameter int POR_SHORT_CYCLES = POR_SHORT_US * CLK_MHZ,
   parameter int POR_LONG_CYCLES  = POR_LONG_US * CLK_MHZ
) (
   input  wire logic              clk,
   input  wire logic              nrst,
   input  wire logic              supply_ok,
   input  wire logic              por_delay_select,
   input  wire logic [PAGE_W-1:0] page_select,
   input  wire logic              chip_select_in,
   input  wire logic              fpga_status_low,
   input  wire logic              fpga_config_complete,
   input  wire logic              external_clock_in,
   input  wire logic              config_reset_line_in,
   output logic                   config_reset_line_out,
   output logic                   config_reset_line_oe,
   output logic                   config_clock_out,
   output logic [DATA_W-1:0]      config_data,
   output logic [ADDR_W-1:0]      flash_addr,
   input  wire logic [DATA_W-1:0] flash_data,
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [7:0]        wb_adr_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [31:0]       wb_dat_i,
   output logic [31:0]            wb_dat_o,
   output logic                   wb_ack_o
);

   // ************************************************************
   // elaboration checks
   // ************************************************************
   if (POR_SHORT_CYCLES < 1 || POR_LONG_CYCLES < 1 ||
       POR_SHORT_CYCLES >= 2**CNT_W || POR_LONG_CYCLES >= 2**CNT_W) begin : g_bad_por
      $error("por cycle counts must fit the hold counter");
   end

   // ************************************************************
   // input synchronisers
   // ************************************************************
   localparam int SYNC_W = 10 + DATA_W;

   logic [SYNC_W-1:0] sync_in;
   logic [SYNC_W-1:0] sync_out;
   logic              supply_s;
   logic              por_sel_s;
   logic [PAGE_W-1:0] page_s;
   logic              cs_s;
   logic              status_s;
   logic              complete_s;
   logic              ext_s;
   logic              line_s;
   logic [DATA_W-1:0] flash_data_s;

   // flash data only matters once it has settled for the current address
   assign sync_in = {supply_ok, por_delay_select, page_select, chip_select_in,
                     fpga_status_low, fpga_config_complete, external_clock_in,
                     config_reset_line_in, flash_data};

   ccp_sync #(
      .WIDTH (SYNC_W)
   ) u_sync (
      .clk  (clk),
      .nrst (nrst),
      .d    (sync_in),
      .q    (sync_out)
   );

   assign {supply_s, por_sel_s, page_s, cs_s, status_s, complete_s, ext_s,
           line_s, flash_data_s} = sync_out;

   // ************************************************************
   // state and registers
   // ************************************************************
   ccp_state_t        state;
   ccp_state_t        next_state;
   logic [CNT_W-1:0]  timer;
   logic [CNT_W-1:0]  next_timer;
   logic              next_err_evt;
   logic              ext_sel;
   logic [DIV_W-1:0]  clk_div;
   logic [LEN_W-1:0]  cfg_len;
   logic              err_flag;
   logic              cs_sample;
   logic              ext_prev;
   logic              supply_prev;
   logic [DIV_W-1:0]  div_cnt;
   logic [LEN_W-1:0]  byte_cnt;

   // ************************************************************
   // decode and selection
   // ************************************************************
   logic              wb_req;
   logic              wr_en;
   logic              hit_ctrl;
   logic              hit_len;
   logic              hit_stat;
   logic [31:0]       ctrl_word;
   logic [31:0]       len_word;
   logic [31:0]       status_word;
   logic [31:0]       rd_data;
   logic              err_clr;
   logic [CNT_W-1:0]  por_cycles;
   logic [DIV_W-1:0]  eff_div;
   logic [LEN_W-1:0]  eff_len;
   logic              last_byte;
   logic              tick_int;
   logic              tick_ext;
   logic              tick;
   logic              in_config;
   logic              load_first;

   assign wb_req      = wb_cyc_i & wb_stb_i;
   assign wr_en       = wb_req & wb_we_i & wb_ack_o;
   assign hit_ctrl    = wb_adr_i == ADDR_CTRL;
   assign hit_len     = wb_adr_i == ADDR_LEN;
   assign hit_stat    = wb_adr_i == ADDR_STATUS;
   assign ctrl_word   = {16'h0000, clk_div, 7'h00, ext_sel};
   assign len_word    = {16'h0000, cfg_len};
   assign status_word = {7'h00, err_flag, 5'h00, page_s, 7'h00, cs_sample, 2'h0, state};
   assign rd_data     = hit_ctrl ? ctrl_word :
                        hit_len  ? len_word  :
                        hit_stat ? status_word : 32'h0000_0000;
   assign err_clr     = wr_en & hit_stat & wb_sel_i[3] & wb_dat_i[STAT_ERR_BIT];

   assign por_cycles  = por_sel_s ? CNT_W'(POR_SHORT_CYCLES)
                                  : CNT_W'(POR_LONG_CYCLES);
   // below the minimum the flash data would not settle before it is sent
   assign eff_div     = (clk_div < DIV_MIN) ? DIV_MIN : clk_div;
   assign eff_len     = (cfg_len == 16'h0000) ? 16'h0001 : cfg_len;
   assign last_byte   = byte_cnt == eff_len;
   assign in_config   = state == ST_CONFIG;
   assign tick_int    = div_cnt == 8'h00;
   assign tick_ext    = ext_s & ~ext_prev;
   // outside configuration the external clock reaches nothing
   assign tick        = in_config & (ext_sel ? tick_ext : tick_int);
   assign load_first  = (state == ST_WAIT_RISE) & (next_state == ST_CONFIG);

   // ************************************************************
   // sequencer
   // ************************************************************
   always_comb begin
      next_state   = state;
      next_timer   = timer;
      next_err_evt = 1'b0;
      if (!supply_s) begin
         // supply loss always restarts the hold picked by the delay select, also out of idle
         next_state = ST_RESET;
         next_timer = por_cycles;
      end else if (!status_s && state != ST_RESET && state != ST_IDLE) begin
         next_state = ST_RESET;
         next_timer = RESTART_CNT;
      end else begin
         unique case (state)
            ST_RESET: begin
               if (!supply_prev) begin
                  // synced select is only valid once supply reads good
                  next_timer = por_cycles;
               end else if (timer == '0) begin
                  next_state = ST_WAIT_RISE;
               end else begin
                  next_timer = timer - CNT_W'(1);
               end
            end
            ST_WAIT_RISE: begin
               // line still low means someone else extends the hold
               if (line_s) begin
                  next_state = cs_s ? ST_IDLE : ST_CONFIG;
               end
            end
            ST_CONFIG: begin
               if (complete_s) begin
                  next_state = ST_USER;
               end else if (tick && config_clock_out && last_byte) begin
                  next_state = ST_CHECK;
                  next_timer = DONE_WAIT_CNT;
               end
            end
            ST_CHECK: begin
               if (complete_s) begin
                  next_state = ST_USER;
               end else if (timer == '0) begin
                  next_state   = ST_RESET;
                  next_timer   = RESTART_CNT;
                  next_err_evt = 1'b1;
               end else begin
                  next_timer = timer - CNT_W'(1);
               end
            end
            ST_USER: begin
               next_state = ST_USER;
            end
            ST_IDLE: begin
               next_state = ST_IDLE;
            end
            default: begin
               next_state = ST_RESET;
               next_timer = por_cycles;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         state       <= ST_RESET;
         timer       <= '0;
         supply_prev <= 1'b0;
      end else begin
         state       <= next_state;
         timer       <= next_timer;
         supply_prev <= supply_s;
      end
   end

   // line drive is open drain: oe high pulls the shared line low
   always_ff @(posedge clk) begin
      if (!nrst) begin
         config_reset_line_oe  <= 1'b1;
         config_reset_line_out <= 1'b0;
      end else begin
         config_reset_line_oe  <= next_state == ST_RESET;
         config_reset_line_out <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         cs_sample <= 1'b0;
      end else if (state == ST_WAIT_RISE && line_s) begin
         cs_sample <= cs_s;
      end
   end

   // ************************************************************
   // configuration clock and data
   // ************************************************************
   always_ff @(posedge clk) begin
      if (!nrst) begin
         ext_prev <= 1'b0;
         div_cnt  <= '0;
      end else begin
         ext_prev <= ext_s;
         if (!in_config || tick_int) begin
            div_cnt <= eff_div - 8'h01;
         end else begin
            div_cnt <= div_cnt - 8'h01;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         config_clock_out <= 1'b0;
         config_data      <= '0;
         flash_addr       <= '0;
         byte_cnt         <= '0;
      end else if (state == ST_RESET) begin
         config_clock_out <= 1'b0;
         flash_addr       <= {page_s, 16'h0000};
         byte_cnt         <= '0;
      end else if (load_first) begin
         config_data <= flash_data_s;
         flash_addr  <= {flash_addr[ADDR_W-1:LEN_W], 16'h0001};
         byte_cnt    <= 16'h0001;
      end else if (tick) begin
         config_clock_out <= ~config_clock_out;
         if (config_clock_out && !last_byte) begin
            config_data <= flash_data_s;
            flash_addr  <= {flash_addr[ADDR_W-1:LEN_W], byte_cnt + 16'h0001};
            byte_cnt    <= byte_cnt + 16'h0001;
         end
      end
   end

   // ************************************************************
   // wishbone slave
   // ************************************************************
   always_ff @(posedge clk) begin
      if (!nrst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_req & ~wb_ack_o;
         wb_dat_o <= (wb_req & ~wb_ack_o) ? rd_data : 32'h0000_0000;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         ext_sel <= 1'b0;
         clk_div <= DIV_RESET;
         cfg_len <= LEN_RESET;
      end else if (wr_en) begin
         if (hit_ctrl && wb_sel_i[0]) begin
            ext_sel <= wb_dat_i[CTRL_EXT_BIT];
         end
         if (hit_ctrl && wb_sel_i[1]) begin
            clk_div <= wb_dat_i[CTRL_DIV_LSB +: DIV_W];
         end
         if (hit_len && wb_sel_i[0]) begin
            cfg_len[7:0] <= wb_dat_i[7:0];
         end
         if (hit_len && wb_sel_i[1]) begin
            cfg_len[15:8] <= wb_dat_i[15:8];
         end
      end
   end

   // a new error in the clearing cycle survives
   always_ff @(posedge clk) begin
      if (!nrst) begin
         err_flag <= 1'b0;
      end else if (next_err_evt) begin
         err_flag <= 1'b1;
      end else if (err_clr) begin
         err_flag <= 1'b0;
      end
   end

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   AST_DELAY_SELECT: assert property (
      (!supply_s && state != ST_IDLE) |=>
         timer == ($past(por_sel_s) ? CNT_W'(POR_SHORT_CYCLES) : CNT_W'(POR_LONG_CYCLES)))
      else $error("hold delay does not follow delay select");

   AST_HOLD_DRIVE: assert property (
      (state == ST_RESET && timer != '0) |=> config_reset_line_oe)
      else $error("reset line released before hold expired");

   AST_HOLD_RELEASE: assert property (
      (state == ST_RESET && timer == '0 && supply_s) |=>
         state == ST_WAIT_RISE && !config_reset_line_oe)
      else $error("reset line not released after hold");

   AST_LINE_HELD: assert property (
      (state == ST_WAIT_RISE && !line_s && supply_s && status_s) |=>
         state == ST_WAIT_RISE)
      else $error("left reset while line held low");

   AST_SUPPLY_LOSS: assert property (
      !supply_s |=> state == ST_RESET ##0 config_reset_line_oe)
      else $error("supply loss did not restart reset");

   AST_STATUS_RESET: assert property (
      (!status_s && supply_s && state inside {ST_WAIT_RISE, ST_CONFIG, ST_CHECK, ST_USER})
         |=> state == ST_RESET && timer == RESTART_CNT)
      else $error("status low did not enter reset");

   AST_ERROR_RESET: assert property (
      (state == ST_CHECK && timer == '0 && !complete_s && supply_s && status_s) |=>
         state == ST_RESET && config_reset_line_oe && err_flag)
      else $error("missing completion did not restart");

   AST_SAMPLE_IDLE: assert property (
      (state == ST_WAIT_RISE && line_s && cs_s && supply_s && status_s) |=>
         state == ST_IDLE && cs_sample)
      else $error("high select at line rise did not idle");

   AST_IDLE_STATIC: assert property (
      (state == ST_IDLE) |=> $stable(config_clock_out) && $stable(config_data))
      else $error("clock or data moved in idle");

   AST_IDLE_STICKY: assert property (
      (state == ST_IDLE && supply_s) |=> state == ST_IDLE)
      else $error("idle left without power cycle");

   AST_SAMPLE_CONFIG: assert property (
      (state == ST_WAIT_RISE && line_s && !cs_s && supply_s && status_s) |=>
         state == ST_CONFIG && config_data == $past(flash_data_s))
      else $error("low select at line rise did not configure");

   AST_PAGE_ADDR: assert property (
      (state == ST_RESET) |=> flash_addr == {$past(page_s), 16'h0000})
      else $error("flash address not at selected page");

   AST_EXT_CLOCK: assert property (
      (in_config && ext_sel && tick_ext) |=> config_clock_out != $past(config_clock_out))
      else $error("external clock edge did not step config clock");

   AST_USER_STATIC: assert property (
      (state == ST_USER) |=> $stable(config_clock_out) && $stable(flash_addr))
      else $error("activity in user mode");

endmodule : ccp_por_seq

// ### testbench/ccp_fpga_model.sv
`timescale 1ns/1ps
module ccp_fpga_model (
   input  wire logic       line,
   input  wire logic       cfg_clk,
   input  wire logic [7:0] data,
   input  wire logic       hold,
   input  wire logic       stat_req,
   input  wire integer     done_at,
   output logic            hold_oe,
   output logic            status_n,
   output logic            done,
   output int              rx_n,
   output logic [7:0]      rx [0:7]
);
   // ************************************************************
   // fpga side of the link
   // ************************************************************
   // no boundary-scan or programming traffic is ever issued here
   assign hold_oe  = hold;
   assign status_n = ~stat_req;
   // done_at 0 mimics an unpowered fpga whose pull-up shows done high
   assign done     = (rx_n >= done_at);
   always @(posedge cfg_clk or negedge line) begin
      if (!line) begin
         rx_n <= 0;
      end else begin
         if (rx_n < 8) rx[rx_n] <= data;
         rx_n <= rx_n + 1;
      end
   end
endmodule : ccp_fpga_model

// ### testbench/ccp_por_seq_tb_top.sv
`timescale 1ns/1ps
module ccp_por_seq_tb_top
   import ccp_pkg::*;
;
   localparam int NS = 20;
   localparam int NL = 60;
   logic        clk, nrst, sup, psel, xclk, st_req, hold, oe, lo, cfg_clk, ack;
   logic        cyc, stb, we, fdone, fstat, hoe, line;
   logic [2:0]  page;
   logic [3:0]  sel, xc;
   logic [7:0]  dat, adr, fdat;
   logic [7:0]  rx [0:7];
   logic [18:0] faddr;
   logic [31:0] wdat, rdat, r;
   int          done_at, rx_n, err_total, samples_checked, ndclk, n, k;
   // ************************************************************
   // environment
   // ************************************************************
   assign line = ~(oe | hoe);
   assign fdat = {faddr[18:16], faddr[4:0]};
   initial begin
      clk = 0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      xc   <= xc + 4'h1;
      xclk <= xc[3];
   end
   always @(posedge cfg_clk) ndclk++;
   ccp_por_seq #(.POR_SHORT_CYCLES(NS), .POR_LONG_CYCLES(NL)) dut (
      .clk(clk), .nrst(nrst), .supply_ok(sup), .por_delay_select(psel),
      .page_select(page), .chip_select_in(fdone), .fpga_status_low(fstat),
      .fpga_config_complete(fdone), .external_clock_in(xclk),
      .config_reset_line_in(line), .config_reset_line_out(lo),
      .config_reset_line_oe(oe), .config_clock_out(cfg_clk), .config_data(dat),
      .flash_addr(faddr), .flash_data(fdat), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack));
   ccp_fpga_model fpga (.line(line), .cfg_clk(cfg_clk), .data(dat), .hold(hold),
      .stat_req(st_req), .done_at(done_at), .hold_oe(hoe), .status_n(fstat),
      .done(fdone), .rx_n(rx_n), .rx(rx));
   // ************************************************************
   // shared tasks
   // ************************************************************
   task automatic end_sim;
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         err_total++;
         $display("Error at %0t got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic tmo;
      err_total++;
      end_sim();
   endtask : tmo
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
      @(posedge clk);
      {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, s};
      n = 0;
      do begin
         @(posedge clk);
         n++;
         if (n > 20) tmo();
      end while (ack !== 1'b1);
      r = rdat;
      {cyc, stb} <= 2'b00;
   endtask : wb
   task automatic wait_oe(input logic v, input int lim);
      n = 0;
      while (oe !== v) begin
         @(posedge clk);
         n++;
         if (n > lim) tmo();
      end
   endtask : wait_oe
   task automatic wait_done;
      n = 0;
      while (fdone !== 1'b1) begin
         @(posedge clk);
         n++;
         if (n > 400) tmo();
      end
      repeat (8) @(posedge clk);
   endtask : wait_done
   // supply drop and return counts as a fresh power-up
   task automatic por(input logic s, input logic [2:0] p);
      @(posedge clk);
      // power-good keeps the fpga asking for reset while the supply is down
      {sup, psel, page, st_req} <= {1'b0, s, p, 1'b1};
      repeat (6) @(posedge clk);
      chk(oe, 1);
      chk(lo, 0);
      {sup, st_req} <= 2'b10;
      wait_oe(0, 300);
      chk(n >= (s ? NS : NL) && n <= (s ? NS : NL) + 8, 1);
   endtask : por
   task automatic stat(input logic [31:0] m, input logic [31:0] e);
      wb(0, ADDR_STATUS, 0, 4'hf);
      chk(r & m, e);
   endtask : stat
   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic s_regs;
      wb(0, ADDR_LEN, 0, 4'hf);
      chk(r, 32'h0000_0100);
      wb(0, ADDR_CTRL, 0, 4'hf);
      chk(r, 32'h0000_0400);
      wb(1, ADDR_LEN, 32'h0000_0004, 4'hf);
      wb(1, 8'h40, 32'hffff_ffff, 4'hf);
      wb(0, 8'h40, 0, 4'hf);
      chk(r, 32'h0);
      wb(0, ADDR_LEN, 0, 4'hf);
      chk(r, 32'h0000_0004);
   endtask : s_regs
   task automatic s_pages;
      for (int p = 0; p < 8; p++) begin
         por(p[0], p[2:0]);
         wait_done();
         chk(n < 80, 1);
         chk(rx_n, 4);
         for (int b = 0; b < 4; b++) chk(rx[b], {p[2:0], b[4:0]});
         stat(32'h0007_013f, {13'h0, p[2:0], 16'h0010});
      end
   endtask : s_pages
   task automatic s_idle;
      done_at = 0;
      por(1, 0);
      repeat (4) @(posedge clk);
      stat(32'h0000_013f, 32'h0000_0120);
      k = ndclk;
      st_req <= 1;
      repeat (60) @(posedge clk);
      chk(oe, 0);
      chk(ndclk, k);
      st_req <= 0;
      stat(32'h3f, 32'h20);
      done_at = 4;
   endtask : s_idle
   task automatic s_hold;
      hold <= 1;
      por(1, 1);
      k = ndclk;
      repeat (100) @(posedge clk);
      chk(ndclk, k);
      stat(32'h3f, 32'h02);
      hold <= 0;
      wait_done();
      stat(32'h3f, 32'h10);
   endtask : s_hold
   task automatic s_fault;
      done_at = 99;
      por(1, 3);
      repeat (6) @(posedge clk);
      st_req <= 1;
      repeat (6) @(posedge clk);
      chk(oe, 1);
      st_req <= 0;
      wait_oe(0, 700);
      wait_oe(1, 1300);
      chk(n >= 1000 && n <= 1100, 1);
      stat(32'h0100_003f, 32'h0100_0001);
      wb(1, ADDR_STATUS, 32'h0100_0000, 4'h8);
      stat(32'h0100_0000, 32'h0);
      done_at = 4;
      wait_oe(0, 700);
      wait_done();
      stat(32'h3f, 32'h10);
   endtask : s_fault
   task automatic s_extclk;
      wb(1, ADDR_CTRL, 32'h0000_0401, 4'h1);
      por(1, 6);
      wait_done();
      chk(n >= 80, 1);
      chk(rx[3], {3'h6, 5'h3});
      k = ndclk;
      r = dat;
      repeat (100) @(posedge clk);
      chk(ndclk, k);
      chk(dat, r);
   endtask : s_extclk
   initial begin
      {nrst, sup, psel, page, xc, st_req, hold} = '0;
      {cyc, stb, we, adr, sel, wdat} = '0;
      {err_total, samples_checked, ndclk} = '0;
      sup = 1;
      psel = 1;
      done_at = 4;
      repeat (10) @(posedge clk);
      nrst <= 1;
      wait_oe(0, 300);
      chk(n >= NS && n <= NS + 8, 1);
      wait_done();
      s_regs();
      s_pages();
      s_idle();
      s_hold();
      s_fault();
      s_extclk();
      end_sim();
   end
endmodule : ccp_por_seq_tb_top
